// [pkg/flash_wake_defs.vh]
`ifndef FLASH_WAKE_DEFS_VH
`define FLASH_WAKE_DEFS_VH

// Instruction codes (build-time defaults, overridable per instance)
`define WAKE_SIG_OPCODE 8'hab
`define WRITE_LATCH_SET_OPCODE 8'h06
`define PAGE_WRITE_OPCODE 8'h02
`define REGION_CLEAR_OPCODE 8'hd8
`define WHOLE_ARRAY_CLEAR_OPCODE 8'hc7
`define STATUS_WRITE_OPCODE 8'h01
`define LOWEST_POWER_OPCODE 8'hb9

// Legacy signature byte; the value is arbitrary
`define LEGACY_SIGNATURE 8'h5a

// Frame bit positions
`define OPCODE_BITS 6'h08
`define SIG_START_BITS 6'h20
`define SIG_DONE_BITS 6'h28
`define BIT_CNT_W 6
`define SIG_MSB 3'h7

// Status layout and delivered values
`define STATUS_BUSY_BIT 0
`define STATUS_WLATCH_BIT 1
`define STATUS_RESET_VALUE 8'h00
`define ERASED_BYTE_VALUE 8'hff

// Timing in ns and the clock period in ns
`define MCLK_PERIOD_NS 100
`define LOCKOUT_MIN_NS 1000000
`define WAKE_PARTIAL_MAX_NS 3000
`define WAKE_FULL_MAX_NS 30000
`define TIMER_W 24
`define MIN_WAKE_CYC 1

// Power modes
`define MODE_STANDBY 2'h0
`define MODE_DEEP 2'h1
`define MODE_WAKING 2'h2

`endif

// [design/flash_wake_signature_powerup.v]
`include "flash_wake_defs.vh"

module flash_wake_signature_powerup #(
  parameter [7:0] WAKE_OPCODE = `WAKE_SIG_OPCODE,
  parameter [7:0] SIGNATURE = `LEGACY_SIGNATURE,
  parameter [7:0] WLATCH_OPCODE = `WRITE_LATCH_SET_OPCODE,
  parameter [7:0] PAGE_OPCODE = `PAGE_WRITE_OPCODE,
  parameter [7:0] REGION_OPCODE = `REGION_CLEAR_OPCODE,
  parameter [7:0] WHOLE_OPCODE = `WHOLE_ARRAY_CLEAR_OPCODE,
  parameter [7:0] STATUS_OPCODE = `STATUS_WRITE_OPCODE,
  parameter [7:0] SLEEP_OPCODE = `LOWEST_POWER_OPCODE,
  parameter LOCKOUT_NS = `LOCKOUT_MIN_NS,
  parameter WAKE_PARTIAL_NS = `WAKE_PARTIAL_MAX_NS,
  parameter WAKE_FULL_NS = `WAKE_FULL_MAX_NS
) (
  input wire mclk,
  input wire rst,
  input wire por_active,
  input wire cs_n,
  input wire sclk,
  input wire mosi,
  input wire cycle_busy,
  output reg miso,
  output reg miso_oe,
  output reg deep_pd,
  output reg standby,
  output reg write_lockout,
  output reg write_req,
  output reg [7:0] write_op,
  output reg [7:0] status_byte,
  output reg [7:0] erased_fill
);

  ////////////////////////////////////////////////////////////////////////////
  // Delay counts: a least time rounds up, a longest time rounds down.
  // Worked in integers first, then cut to the timer width on purpose,
  // so an oversized parameter wraps visibly rather than padding silently.
  localparam integer LOCKOUT_RAW =
    (LOCKOUT_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS;
  localparam integer PARTIAL_RAW = WAKE_PARTIAL_NS / `MCLK_PERIOD_NS;
  localparam integer FULL_RAW = WAKE_FULL_NS / `MCLK_PERIOD_NS;
  // A wake delay below one clock still costs one cycle in the waking state
  localparam integer PARTIAL_CLAMP =
    (PARTIAL_RAW < `MIN_WAKE_CYC) ? `MIN_WAKE_CYC : PARTIAL_RAW;
  localparam integer FULL_CLAMP =
    (FULL_RAW < `MIN_WAKE_CYC) ? `MIN_WAKE_CYC : FULL_RAW;
  localparam [`TIMER_W-1:0] LOCKOUT_CYC = LOCKOUT_RAW[`TIMER_W-1:0];
  localparam [`TIMER_W-1:0] PARTIAL_CYC = PARTIAL_CLAMP[`TIMER_W-1:0];
  localparam [`TIMER_W-1:0] FULL_CYC = FULL_CLAMP[`TIMER_W-1:0];
  localparam [`TIMER_W-1:0] TIMER_ZERO = {`TIMER_W{1'b0}};
  localparam [`TIMER_W-1:0] TIMER_ONE = {{(`TIMER_W-1){1'b0}}, 1'b1};

  // Write-class opcode decode, shared by latch-set and request logic
  function is_write_class;
    input [7:0] op;
    begin
      is_write_class = (op == WLATCH_OPCODE) || (op == PAGE_OPCODE) ||
        (op == REGION_OPCODE) || (op == WHOLE_OPCODE) || (op == STATUS_OPCODE);
    end
  endfunction

  // Timer step shared by the wake and lockout counters
  function [`TIMER_W-1:0] timer_dec;
    input [`TIMER_W-1:0] value;
    begin
      // Saturate at zero so a stray extra tick never wraps to a long wait
      if (value == TIMER_ZERO)
        timer_dec = TIMER_ZERO;
      else
        timer_dec = value - TIMER_ONE;
    end
  endfunction

  // True on the last counted cycle of a timer
  function timer_last;
    input [`TIMER_W-1:0] value;
    begin
      timer_last = (value <= TIMER_ONE);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  // Chip select chain; the third stage only feeds the edge detector
  reg cs_s1_reg;
  reg cs_s2_reg;
  reg cs_s3_reg;
  // Link clock chain; the third stage only feeds the edge detector
  reg sclk_s1_reg;
  reg sclk_s2_reg;
  reg sclk_s3_reg;
  // Data chain is one stage shorter, so it lines up with the clock edge
  reg mosi_s1_reg;
  reg mosi_s2_reg;
  // Power-on indication chain
  reg por_s1_reg;
  reg por_s2_reg;

  // Reset values match the idle pin levels, so no false edge follows reset;
  // the power-on chain resets high so the hold is released cleanly
  always @(posedge mclk) begin
    if (rst) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      mosi_s1_reg <= 1'b0;
      mosi_s2_reg <= 1'b0;
      por_s1_reg <= 1'b1;
      por_s2_reg <= 1'b1;
    end else begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      sclk_s1_reg <= sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      mosi_s1_reg <= mosi;
      mosi_s2_reg <= mosi_s1_reg;
      por_s1_reg <= por_active;
      por_s2_reg <= por_s1_reg;
    end
  end

  // Power-on indication holds all functional state in reset; it is seen two
  // clocks late on both edges, which only stretches the hold a little
  wire hold = rst | por_s2_reg;
  wire selected = ~cs_s2_reg;
  // Edges are found two clocks after the pin moves; the link clock must keep
  // each phase longer than one clock or an edge can be lost
  wire sclk_rise = selected & sclk_s2_reg & ~sclk_s3_reg;
  wire sclk_fall = selected & ~sclk_s2_reg & sclk_s3_reg;
  wire cs_rise = cs_s2_reg & ~cs_s3_reg;
  wire cs_fall = ~cs_s2_reg & cs_s3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame capture: opcode shift and saturating bit count.
  // Everything here clears at the start of each frame, so nothing left
  // over from an earlier command can act on a later deselect.
  reg [`BIT_CNT_W-1:0] bit_cnt_reg;
  reg [6:0] op_sh_reg;
  reg [7:0] opcode_reg;
  reg res_frame_reg;
  reg [2:0] sig_idx_reg;
  // Opcode as it stands including the bit being taken this cycle
  wire [7:0] op_now = {op_sh_reg, mosi_s2_reg};
  wire op_done = sclk_rise && (bit_cnt_reg == `OPCODE_BITS - 6'h01);

  // Power mode, timers and status latches
  reg [1:0] mode_reg;
  reg [`TIMER_W-1:0] wake_cnt_reg;
  reg [`TIMER_W-1:0] lock_cnt_reg;
  reg wlatch_reg;
  reg busy_reg;

  // Count rising edges, stop once a full signature has passed
  // Saturating keeps the frame-length tests valid for long repeated reads
  // without a wider counter
  always @(posedge mclk) begin
    if (hold || cs_fall) begin
      bit_cnt_reg <= {`BIT_CNT_W{1'b0}};
      op_sh_reg <= 7'h00;
    end else if (sclk_rise) begin
      if (bit_cnt_reg != `SIG_DONE_BITS)
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      if (bit_cnt_reg < `OPCODE_BITS)
        op_sh_reg <= op_now[6:0];
    end
  end

  // Latch opcode; wake command is undecoded while a write cycle runs
  // and is also ignored while a wake delay is still counting
  always @(posedge mclk) begin
    if (hold || cs_fall) begin
      opcode_reg <= 8'h00;
      res_frame_reg <= 1'b0;
    end else if (op_done) begin
      opcode_reg <= op_now;
      res_frame_reg <= (op_now == WAKE_OPCODE) && !busy_reg &&
        (mode_reg != `MODE_WAKING);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Signature output on falling edges, wrapping for repeated reads.
  // The first bit leaves on the fall after the last dummy bit; the index
  // then wraps so continued clocking repeats the byte.
  // Limitation: a fall seen in the same clock as deselect is dropped.
  // The driver turns off one clock after the deselect is seen.
  always @(posedge mclk) begin
    if (hold) begin
      miso <= 1'b0;
      miso_oe <= 1'b0;
      sig_idx_reg <= `SIG_MSB;
    end else if (!selected) begin
      miso_oe <= 1'b0;
      sig_idx_reg <= `SIG_MSB;
    end else if (sclk_fall && res_frame_reg && bit_cnt_reg >= `SIG_START_BITS) begin
      miso <= SIGNATURE[sig_idx_reg];
      miso_oe <= 1'b1;
      sig_idx_reg <= sig_idx_reg - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode machine; deep mode only through the sleep opcode.
  // Deep entry is immediate at deselect; the settle time before low current
  // is left to the supply side, which trades accuracy for a smaller block.
  localparam [1:0] ST_STANDBY = `MODE_STANDBY;
  localparam [1:0] ST_DEEP = `MODE_DEEP;
  localparam [1:0] ST_WAKING = `MODE_WAKING;

  wire frame_has_op = bit_cnt_reg >= `OPCODE_BITS;
  wire exact_op = bit_cnt_reg == `OPCODE_BITS;
  wire full_sig = bit_cnt_reg == `SIG_DONE_BITS;

  always @(posedge mclk) begin
    if (hold) begin
      mode_reg <= ST_STANDBY;
      wake_cnt_reg <= {`TIMER_W{1'b0}};
    end else begin
      case (mode_reg)
        ST_STANDBY: begin
          // a wake command while awake leaves us in standby
          if (cs_rise && exact_op && opcode_reg == SLEEP_OPCODE && !busy_reg)
            mode_reg <= ST_DEEP;
        end
        ST_DEEP: begin
          // Anything but the wake command is dropped here
          if (cs_rise && res_frame_reg && frame_has_op) begin
            mode_reg <= ST_WAKING;
            wake_cnt_reg <= full_sig ? FULL_CYC : PARTIAL_CYC;
          end
        end
        ST_WAKING: begin
          // Host keeps chip select high across this; frames are ignored
          if (timer_last(wake_cnt_reg)) begin
            mode_reg <= ST_STANDBY;
            wake_cnt_reg <= TIMER_ZERO;
          end else begin
            wake_cnt_reg <= timer_dec(wake_cnt_reg);
          end
        end
        default: begin
          // Unused code: fall back to the safe awake state
          mode_reg <= ST_STANDBY;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write lockout timer runs from power-on release; reads are not gated.
  // It reloads for as long as the hold lasts, so a supply dip restarts it.
  always @(posedge mclk) begin
    if (hold)
      lock_cnt_reg <= LOCKOUT_CYC;
    else
      lock_cnt_reg <= timer_dec(lock_cnt_reg);
  end

  // Write-class acceptance needs a whole opcode and every gate open;
  // lockout, deep mode and a running cycle each block it on their own
  wire locked = lock_cnt_reg != TIMER_ZERO;
  wire write_gate_open = !locked && mode_reg == ST_STANDBY && !busy_reg;
  wire write_frame = cs_rise && frame_has_op && is_write_class(opcode_reg);
  wire write_ok = write_frame && write_gate_open;

  // Write latch and busy; busy is the running write cycle seen from the core.
  // The latch drops when the running cycle ends, not when it starts, so a
  // status poll during the cycle still shows the latch that allowed it.
  // The busy input shares this clock and needs no synchroniser.
  always @(posedge mclk) begin
    if (hold) begin
      wlatch_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= cycle_busy;
      // Latch set wins over the end-of-cycle clear in the same cycle
      if (write_ok && exact_op && opcode_reg == WLATCH_OPCODE)
        wlatch_reg <= 1'b1;
      else if (busy_reg && !cycle_busy)
        wlatch_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status image: busy and latch bits live, every other bit reads zero
  reg [7:0] status_next;
  always @* begin
    status_next = `STATUS_RESET_VALUE;
    status_next[`STATUS_BUSY_BIT] = busy_reg;
    status_next[`STATUS_WLATCH_BIT] = wlatch_reg;
  end

  // Registered outputs; write requests need the latch except the latch-set itself.
  // Every output comes from a flop, so each lags its cause by one clock.
  // The array itself lives outside; only its delivered fill value is shown.
  always @(posedge mclk) begin
    if (hold) begin
      deep_pd <= 1'b0;
      standby <= 1'b1;
      write_lockout <= 1'b1;
      write_req <= 1'b0;
      write_op <= 8'h00;
      status_byte <= `STATUS_RESET_VALUE;
      erased_fill <= `ERASED_BYTE_VALUE;
    end else begin
      deep_pd <= mode_reg == ST_DEEP;
      standby <= mode_reg == ST_STANDBY && !selected;
      write_lockout <= locked;
      write_req <= write_ok && opcode_reg != WLATCH_OPCODE && wlatch_reg;
      if (write_ok)
        write_op <= opcode_reg;
      status_byte <= status_next;
      erased_fill <= `ERASED_BYTE_VALUE;
    end
  end

endmodule // flash_wake_signature_powerup

// [bench/flash_wake_monitor.sv]
module flash_wake_monitor (
  input wire mclk,
  input wire rst,
  input wire por_active,
  input wire cs_n,
  input wire miso_oe,
  input wire deep_pd,
  input wire standby,
  input wire write_lockout,
  input wire write_req,
  input wire [7:0] status_byte,
  input wire [7:0] erased_fill
);
  timeunit 1ns;
  timeprecision 1ns;
  // Power-on hold is a reset of its own, so it gates every check
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst || por_active);
  ////////////////////////////////////////
  property p_oe_off; cs_n [*6] |-> !miso_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("driver on after deselect");
  property p_fill; erased_fill == 8'hff && status_byte[7:2] == 6'h00; endproperty
  a_fill: assert property (p_fill) else $error("delivered value wrong");
  property p_pwr; $fell(rst) |-> standby && !deep_pd && status_byte == 8'h00; endproperty
  a_pwr: assert property (p_pwr) else $error("power-up state wrong");
  property p_lock; $fell(rst) |-> write_lockout [*8]; endproperty
  a_lock: assert property (p_lock) else $error("lockout too short");
  property p_lock_wr; write_lockout |-> !write_req; endproperty
  a_lock_wr: assert property (p_lock_wr) else $error("write during lockout");
  property p_deep_wr; deep_pd |-> !write_req; endproperty
  a_deep_wr: assert property (p_deep_wr) else $error("write while asleep");
  property p_deep_in; $rose(deep_pd) |-> cs_n; endproperty
  a_deep_in: assert property (p_deep_in) else $error("sleep while selected");
  property p_wake_hold; $fell(deep_pd) |-> !standby [*8]; endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake too fast");
  property p_wake_end; $fell(deep_pd) |-> ##[1:60] standby; endproperty
  a_wake_end: assert property (p_wake_end) else $error("wake too slow");
endmodule // flash_wake_monitor

bind flash_wake_signature_powerup flash_wake_monitor u_mon (
  .mclk(mclk), .rst(rst), .por_active(por_active), .cs_n(cs_n), .miso_oe(miso_oe),
  .deep_pd(deep_pd), .standby(standby), .write_lockout(write_lockout),
  .write_req(write_req), .status_byte(status_byte), .erased_fill(erased_fill)
);

// [bench/spi_host_model.sv]
module spi_host_model (
  input wire mclk,
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire miso
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock stands low between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  ////////////////////////////////////////
  // Half of the 800 ns link period
  task automatic half();
    repeat (4) @(negedge mclk);
  endtask
  // Samples late in the high phase, away from the slow driver update
  task automatic xfer(input logic [7:0] op, input int nbits, output logic [7:0] rx);
    logic [7:0] sh;
    sh = op;
    rx = 8'h00;
    @(negedge mclk);
    cs_n = 1'b0;
    half();
    for (int i = 1; i <= nbits; i++) begin
      mosi = sh[7];
      sh = {sh[6:0], 1'b0};
      half();
      sclk = 1'b1;
      half();
      if (i > 32) rx = {rx[6:0], miso};
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule // spi_host_model

// [bench/tb_top.sv]
`include "flash_wake_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, por_active = 0, cycle_busy = 0, oe_seen = 0, req_seen = 0;
  logic seen_clr = 0;
  wire cs_n, sclk, mosi, miso, miso_oe, deep_pd, standby, write_lockout, write_req;
  wire [7:0] write_op, status_byte, erased_fill;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [7:0] rx;
  typedef struct {logic [7:0] op; int nb; logic busy; logic oe;} row_t;
  row_t rows [4] = '{'{`WAKE_SIG_OPCODE, 40, 1'b0, 1'b1}, '{`WAKE_SIG_OPCODE, 48, 1'b0, 1'b1},
    '{`WAKE_SIG_OPCODE, 40, 1'b1, 1'b0}, '{`WRITE_LATCH_SET_OPCODE, 40, 1'b0, 1'b0}};
  always #50 mclk = ~mclk;
  // Lockout shortened to 800 cycles, wake delays to 10 and 30
  flash_wake_signature_powerup #(.LOCKOUT_NS(80000), .WAKE_PARTIAL_NS(1000),
    .WAKE_FULL_NS(3000)) u_dut (.mclk(mclk), .rst(rst), .por_active(por_active),
    .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .cycle_busy(cycle_busy), .miso(miso),
    .miso_oe(miso_oe), .deep_pd(deep_pd), .standby(standby), .write_lockout(write_lockout),
    .write_req(write_req), .write_op(write_op), .status_byte(status_byte),
    .erased_fill(erased_fill));
  spi_host_model h (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));
  // Sticky flags, since both outputs are short-lived
  always @(posedge mclk) begin
    if (seen_clr) begin
      oe_seen <= 1'b0;
      req_seen <= 1'b0;
    end else begin
      if (miso_oe === 1'b1) oe_seen <= 1'b1;
      if (write_req === 1'b1) req_seen <= 1'b1;
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic frm(input logic [7:0] op, input int nb);
    seen_clr = 1'b1;
    cyc(1);
    seen_clr = 1'b0;
    h.xfer(op, nb, rx);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well above the expected run of about 3600 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    report_and_stop();
  end
  ////////////////////////////////////////
  initial begin
    cyc(16);
    rst = 1'b0;
    frm(`WRITE_LATCH_SET_OPCODE, 8);
    cyc(6);
    frm(`WHOLE_ARRAY_CLEAR_OPCODE, 8);
    cyc(6);
    chk("lock_req", 8'h00, {7'h0, req_seen});
    frm(`WAKE_SIG_OPCODE, 40);
    cyc(6);
    chk("lock_read", `LEGACY_SIGNATURE, rx);
    chk("lock_on", 8'h01, {7'h0, write_lockout});
    for (int i = 0; i < 1000 && write_lockout !== 1'b0; i++) cyc(1);
    frm(`WRITE_LATCH_SET_OPCODE, 8);
    cyc(6);
    frm(`WHOLE_ARRAY_CLEAR_OPCODE, 8);
    cyc(6);
    chk("wr_req", 8'h01, {7'h0, req_seen});
    chk("wr_op", `WHOLE_ARRAY_CLEAR_OPCODE, write_op);
    $display("Lockout test done");
    foreach (rows[i]) begin
      cycle_busy = rows[i].busy;
      frm(rows[i].op, rows[i].nb);
      cyc(8);
      cycle_busy = 1'b0;
      cyc(2);
      chk("oe", {7'h0, rows[i].oe}, {7'h0, oe_seen});
      if (rows[i].oe) chk("sig", `LEGACY_SIGNATURE, rx);
      chk("stby", 8'h01, {7'h0, standby});
      $display("Row %0d done", i);
    end
    frm(`LOWEST_POWER_OPCODE, 8);
    cyc(8);
    chk("deep", 8'h01, {7'h0, deep_pd});
    frm(`WRITE_LATCH_SET_OPCODE, 8);
    cyc(6);
    frm(`WHOLE_ARRAY_CLEAR_OPCODE, 8);
    cyc(6);
    chk("deep_req", 8'h00, {7'h0, req_seen});
    frm(`WAKE_SIG_OPCODE, 40);
    cyc(6);
    chk("sig_deep", `LEGACY_SIGNATURE, rx);
    chk("wake", 8'h00, {6'h0, deep_pd, standby});
    cyc(40);
    chk("wake_end", 8'h01, {6'h0, deep_pd, standby});
    frm(`LOWEST_POWER_OPCODE, 8);
    cyc(8);
    frm(`WAKE_SIG_OPCODE, 16);
    cyc(6);
    chk("part", 8'h00, {6'h0, deep_pd, standby});
    cyc(20);
    chk("part_end", 8'h01, {6'h0, deep_pd, standby});
    $display("Sleep test done");
    por_active = 1'b1;
    cyc(6);
    frm(`WAKE_SIG_OPCODE, 40);
    cyc(4);
    chk("por_oe", 8'h00, {7'h0, oe_seen});
    chk("por_st", 8'h03, {5'h0, deep_pd, standby, write_lockout});
    chk("por_sr", 8'h00, status_byte);
    chk("fill", 8'hff, erased_fill);
    por_active = 1'b0;
    cyc(8);
    chk("por_lock", 8'h01, {7'h0, write_lockout});
    $display("Power-up test done");
    report_and_stop();
  end
endmodule // tb_top
